// ---- core/thermal_alert_timer_logic.sv ----
// Alert masking, pin function select, thermal timer and thermal output
`timescale 1ns/100ps
`include "thermal_alert_defines.svh"
module thermal_alert_timer_logic
  import thermal_alert_pkg::*;
#(
  parameter int TICK_CYCLES = `TIMER_LSB_NS / `CLK_PERIOD_NS
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Register access from the serial front end
  input wire reg_req_s i_reg_req,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Limit comparator conditions, level, high while out of limit
  input wire logic [7:0] i_status1_cond,
  input wire logic [7:0] i_status2_cond,
  // Temperature readings and per-channel update strobes local
  input wire temp_set_s i_temps,
  input wire logic [2:0] i_temp_update,
  input wire logic i_offset64_mode,
  // Fan state and second fan drive
  input wire logic [2:0] i_fan_running,
  input wire logic i_second_fan_drive,
  input wire logic i_gpio_out,
  input wire logic i_gpio_oe,
  // Pins: pin 10, pin 14, pin 20 (open drain pins drive low only)
  output logic o_pin10_out,
  output logic o_pin10_oe,
  input wire logic i_pin14,
  output logic o_pin14_out,
  output logic o_pin14_oe,
  input wire logic i_pin20,
  output logic o_pin20_out,
  output logic o_pin20_oe,
  // Status views
  output logic [2:0] o_fan_boost,
  output logic o_alert_pending,
  output logic o_gpio_in
);

  localparam logic [23:0] TICK_M1 = 24'(TICK_CYCLES - 1);
  localparam logic [23:0] TICK2_M1 = 24'((2 * TICK_CYCLES) - 1);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic wr_hit(input reg_req_s req, input logic [7:0] addr);
    wr_hit = req.wr && (req.addr == addr);
  endfunction

  function automatic logic rd_hit(input reg_req_s req, input logic [7:0] addr);
    rd_hit = req.rd && (req.addr == addr);
  endfunction

  // Channel may drive thermal pin only when enabled and limit not at floor
  function automatic logic crit_armed(input logic [7:0] cfg, input logic [7:0] lim,
                                      input logic ofs64);
    logic floor_hit;
    floor_hit = ofs64 ? (lim == `CRIT_OFF_OFS64) : (lim == `CRIT_OFF_TWOS);
    crit_armed = cfg[`BIT_CH_THERMAL_PIN_EN] && !floor_hit;
  endfunction

  // Temperature above limit, in the comparison format of the channel
  function automatic logic crit_over(input logic [9:0] temp, input logic [7:0] lim,
                                     input logic ofs64);
    logic [9:0] lim_q;
    logic [9:0] t_adj;
    lim_q = {lim, 2'b00};
    t_adj = temp;
    if (!ofs64)
    begin
      lim_q[9] = ~lim_q[9];
      t_adj[9] = ~t_adj[9];
    end
    crit_over = t_adj > lim_q;
  endfunction

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] cfg_r [3];
  logic [7:0] cfg_nxt [3];
  logic [7:0] crit_r [3];
  logic [7:0] crit_nxt [3];
  logic [7:0] mask1_r;
  logic [7:0] mask1_nxt;
  logic [7:0] mask2_r;
  logic [7:0] mask2_nxt;
  logic [7:0] pin_cfg_r;
  logic [7:0] pin_cfg_nxt;
  logic [7:0] tmr_lim_r;
  logic [7:0] tmr_lim_nxt;
  logic [7:0] pin14_cfg_r;
  logic [7:0] pin14_cfg_nxt;
  logic [7:0] cfg_addr [3];
  logic [7:0] crit_addr [3];

  assign cfg_addr[0] = `ADDR_R1_CFG;
  assign cfg_addr[1] = `ADDR_LOC_CFG;
  assign cfg_addr[2] = `ADDR_R2_CFG;
  assign crit_addr[0] = `ADDR_R1_CRIT;
  assign crit_addr[1] = `ADDR_LOC_CRIT;
  assign crit_addr[2] = `ADDR_R2_CRIT;

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      cfg_nxt[i] = wr_hit(i_reg_req, cfg_addr[i]) ? i_reg_req.wdata : cfg_r[i];
      crit_nxt[i] = wr_hit(i_reg_req, crit_addr[i]) ? i_reg_req.wdata : crit_r[i];
    end
    mask1_nxt = wr_hit(i_reg_req, `ADDR_MASK1) ? i_reg_req.wdata : mask1_r;
    mask2_nxt = wr_hit(i_reg_req, `ADDR_MASK2) ? i_reg_req.wdata : mask2_r;
    pin_cfg_nxt = wr_hit(i_reg_req, `ADDR_PIN_CFG) ? i_reg_req.wdata : pin_cfg_r;
    tmr_lim_nxt = wr_hit(i_reg_req, `ADDR_TIMER_LIM) ? i_reg_req.wdata : tmr_lim_r;
    pin14_cfg_nxt = wr_hit(i_reg_req, `ADDR_PIN14_CFG) ? i_reg_req.wdata : pin14_cfg_r;
  end

  // Alert function is off after reset: pin 10 starts as fan drive
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      for (int i = 0; i < 3; i++)
      begin
        cfg_r[i] <= `RST_ZERO;
        crit_r[i] <= `RST_CRIT;
      end
      mask1_r <= `RST_ZERO;
      mask2_r <= `RST_ZERO;
      pin_cfg_r <= `RST_ZERO;
      tmr_lim_r <= `RST_TIMER_LIM;
      pin14_cfg_r <= `RST_ZERO;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      crit_r <= crit_nxt;
      mask1_r <= mask1_nxt;
      mask2_r <= mask2_nxt;
      pin_cfg_r <= pin_cfg_nxt;
      tmr_lim_r <= tmr_lim_nxt;
      pin14_cfg_r <= pin14_cfg_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pin roles and thermal input
  // ----------------------------------------------------------------
  pin14_mode_e multi_pin_select;
  logic thermal_pin_en;
  logic pin14_thermal_pin;
  logic pin20_level;
  logic pin14_level;
  logic thermal_pin_asserted;
  logic ext_low;
  logic drive_d1_r;
  logic drive_d2_r;

  assign multi_pin_select = pin14_mode_e'(pin14_cfg_r[1:0]);
  assign thermal_pin_en = pin_cfg_r[`BIT_THERMAL_PIN_EN];
  assign pin14_thermal_pin = thermal_pin_en && (multi_pin_select == PIN14_THERMAL_PIN);

  pin_sync u_sync20 (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_pin20),
    .o_level(pin20_level)
  );

  pin_sync u_sync14 (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_pin14),
    .o_level(pin14_level)
  );

  assign o_gpio_in = pin14_level;
  assign thermal_pin_asserted = thermal_pin_en && (!pin20_level || (pin14_thermal_pin && !pin14_level));
  // Own drive is seen two cycles late through the synchroniser
  assign ext_low = thermal_pin_asserted && !drive_d2_r;

  // ----------------------------------------------------------------
  // Thermal output from critical limits
  // ----------------------------------------------------------------
  logic [2:0] crit_hot_r;
  logic [2:0] crit_hot_nxt;
  logic [9:0] temp_ch [3];

  assign temp_ch[0] = i_temps.r1;
  assign temp_ch[1] = i_temps.loc;
  assign temp_ch[2] = i_temps.r2;

  // Decision changes only on a fresh reading or when the channel is disarmed, so low holds a full cycle
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      crit_hot_nxt[i] = crit_hot_r[i];
      if (!crit_armed(cfg_r[i], crit_r[i], i_offset64_mode))
        crit_hot_nxt[i] = 1'b0;
      else if (i_temp_update[i])
        crit_hot_nxt[i] = crit_over(temp_ch[i], crit_r[i], i_offset64_mode);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      crit_hot_r <= 3'h0;
      drive_d1_r <= 1'b0;
      drive_d2_r <= 1'b0;
    end
    else
    begin
      crit_hot_r <= crit_hot_nxt;
      drive_d1_r <= |crit_hot_r;
      drive_d2_r <= drive_d1_r;
    end
  end

  // ----------------------------------------------------------------
  // Assertion timer
  // ----------------------------------------------------------------
  timer_state_e tmr_st_r;
  timer_state_e tmr_st_nxt;
  logic [7:0] tmr_val_r;
  logic [7:0] tmr_val_nxt;
  logic [23:0] pre_r;
  logic [23:0] pre_nxt;
  logic tmr_read;

  assign tmr_read = rd_hit(i_reg_req, `ADDR_TIMER);

  always_comb
  begin
    tmr_st_nxt = tmr_st_r;
    tmr_val_nxt = tmr_val_r;
    pre_nxt = pre_r;
    if (tmr_read)
    begin
      // Read clears; an ongoing assertion restarts the count at once
      tmr_val_nxt = thermal_pin_asserted ? `TIMER_FIRST : `RST_ZERO;
      tmr_st_nxt = thermal_pin_asserted ? TMR_FIRST : TMR_IDLE;
      pre_nxt = 24'h0;
    end
    else if (thermal_pin_asserted)
    begin
      unique case (tmr_st_r)
        TMR_IDLE:
        begin
          tmr_val_nxt = `TIMER_FIRST;
          tmr_st_nxt = TMR_FIRST;
          pre_nxt = 24'h0;
        end
        TMR_FIRST:
        begin
          pre_nxt = pre_r + 24'h1;
          if (pre_r == TICK2_M1)
          begin
            tmr_val_nxt = `TIMER_SECOND;
            tmr_st_nxt = TMR_COUNT;
            pre_nxt = 24'h0;
          end
        end
        TMR_COUNT:
        begin
          pre_nxt = pre_r + 24'h1;
          if (pre_r == TICK_M1)
          begin
            tmr_val_nxt = tmr_val_r + 8'h1;
            pre_nxt = 24'h0;
            if (tmr_val_r == (`TIMER_FULL - 8'h1))
              tmr_st_nxt = TMR_FULL;
          end
        end
        TMR_FULL:
        begin
          pre_nxt = 24'h0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      tmr_st_r <= TMR_IDLE;
      tmr_val_r <= `RST_ZERO;
      pre_r <= 24'h0;
    end
    else
    begin
      tmr_st_r <= tmr_st_nxt;
      tmr_val_r <= tmr_val_nxt;
      pre_r <= pre_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Sticky status and alert
  // ----------------------------------------------------------------
  logic [7:0] status1_r;
  logic [7:0] status1_nxt;
  logic [7:0] status2_r;
  logic [7:0] status2_nxt;
  logic [7:0] cond2;
  logic [7:0] cond1;
  logic [7:0] status1_view;
  logic timer_exceeded;
  logic alert_nxt;
  logic [7:0] unmasked1;

  assign timer_exceeded = thermal_pin_en && (tmr_val_nxt > tmr_lim_r);

  always_comb
  begin
    cond2 = i_status2_cond;
    cond2[`BIT_F4P] = thermal_pin_en ? timer_exceeded : i_status2_cond[`BIT_F4P];
    cond2[`BIT_OVT] = i_status2_cond[`BIT_OVT] | (|crit_hot_r);
    cond1 = i_status1_cond;
    cond1[`BIT_SUMMARY] = 1'b0;
    // Set wins over a read in the same cycle
    status1_nxt = cond1 | (rd_hit(i_reg_req, `ADDR_STATUS1) ? 8'h00 : status1_r);
    status2_nxt = cond2 | (rd_hit(i_reg_req, `ADDR_STATUS2) ? 8'h00 : status2_r);
  end

  assign status1_view = {|status2_r, status1_r[6:0]};

  // Mask bit 0 gates the core channel held at status bit 1; bit 0 has no mask
  always_comb
  begin
    unmasked1 = status1_r & ~{1'b0, mask1_r[6:2], mask1_r[`MSK_CORE_V], 1'b0};
    unmasked1[`BIT_SUMMARY] = (|(status2_r & ~mask2_r)) && !mask1_r[`BIT_SUMMARY];
    alert_nxt = |unmasked1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      status1_r <= `RST_ZERO;
      status2_r <= `RST_ZERO;
    end
    else
    begin
      status1_r <= status1_nxt;
      status2_r <= status2_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [7:0] rdata_nxt;

  always_comb
  begin
    rdata_nxt = `RST_ZERO;
    for (int i = 0; i < 3; i++)
    begin
      if (i_reg_req.addr == cfg_addr[i])
        rdata_nxt = cfg_r[i];
      if (i_reg_req.addr == crit_addr[i])
        rdata_nxt = crit_r[i];
    end
    unique case (i_reg_req.addr)
      `ADDR_STATUS1: rdata_nxt = status1_view;
      `ADDR_STATUS2: rdata_nxt = status2_r;
      `ADDR_MASK1: rdata_nxt = mask1_r;
      `ADDR_MASK2: rdata_nxt = mask2_r;
      `ADDR_PIN_CFG: rdata_nxt = pin_cfg_r;
      `ADDR_TIMER: rdata_nxt = tmr_val_r;
      `ADDR_TIMER_LIM: rdata_nxt = tmr_lim_r;
      `ADDR_PIN14_CFG: rdata_nxt = pin14_cfg_r;
      default: ;
    endcase
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic pin10_out_nxt;
  logic pin10_oe_nxt;
  logic pin14_out_nxt;
  logic pin14_oe_nxt;
  logic pin20_oe_nxt;
  logic [2:0] boost_nxt;

  always_comb
  begin
    if (pin_cfg_r[`BIT_ALERT_PIN10])
    begin
      pin10_out_nxt = 1'b0;
      pin10_oe_nxt = alert_nxt;
    end
    else
    begin
      pin10_out_nxt = i_second_fan_drive;
      pin10_oe_nxt = 1'b1;
    end
    pin14_out_nxt = 1'b0;
    pin14_oe_nxt = 1'b0;
    unique case (multi_pin_select)
      PIN14_TACH: pin14_oe_nxt = 1'b0;
      PIN14_THERMAL_PIN: pin14_oe_nxt = pin14_thermal_pin && (|crit_hot_nxt);
      PIN14_ALERT: pin14_oe_nxt = alert_nxt;
      PIN14_GPIO:
      begin
        pin14_out_nxt = i_gpio_out;
        pin14_oe_nxt = i_gpio_oe;
      end
    endcase
    pin20_oe_nxt = thermal_pin_en && (|crit_hot_nxt);
    boost_nxt = (pin_cfg_r[`BIT_BOOST] && ext_low) ? i_fan_running : 3'h0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_reg_rdata <= `RST_ZERO;
      o_reg_rvalid <= 1'b0;
      o_pin10_out <= 1'b0;
      o_pin10_oe <= 1'b0;
      o_pin14_out <= 1'b0;
      o_pin14_oe <= 1'b0;
      o_pin20_out <= 1'b0;
      o_pin20_oe <= 1'b0;
      o_fan_boost <= 3'h0;
      o_alert_pending <= 1'b0;
    end
    else
    begin
      o_reg_rdata <= i_reg_req.rd ? rdata_nxt : o_reg_rdata;
      o_reg_rvalid <= i_reg_req.rd;
      o_pin10_out <= pin10_out_nxt;
      o_pin10_oe <= pin10_oe_nxt;
      o_pin14_out <= pin14_out_nxt;
      o_pin14_oe <= pin14_oe_nxt;
      o_pin20_out <= 1'b0;
      o_pin20_oe <= pin20_oe_nxt;
      o_fan_boost <= boost_nxt;
      o_alert_pending <= alert_nxt;
    end
  end

endmodule

// ---- core/thermal_alert_defines.svh ----
// Constants for the thermal alert and assertion timer logic
// Functional notes
// - Mask bits gate only the alert output; status bits still set normally.
// - First mask: bit7 second-status summary, 6..4 temperatures, 3,2,0 voltages.
// - Second mask: diodes, fans 4..1, overtemperature, 12 V or ID change.
// - With thermal function in use, second-mask bit 5 masks timer events.
// - Alert disabled after reset; pin feature config picks pin 10 role.
// - Pin 14 role from two config bits: tach, thermal, alert, GPIO.
// - Thermal enable makes pin 20 thermal; pin 14 thermal only if enabled.
// - Boost bit forces running fans to full duty on external thermal low.
// - Timer runs while thermal input asserted, pauses, then accumulates.
// - Timer clears on read and saturates at full scale.
// - Bit 0 sets on first assertion; bit 1 after 45.52 ms; LSB 22.76 ms.
// - Read during assertion clears, sets bit 0 again, restarts from zero.
// - Timer above limit sets second-status bit 5 and raises an alert.
// - Limit zero triggers at first assertion; one after 45.52 ms.
// - Thermal pin driven low above critical limit until at or below it.
// - Config bit 3 enables each channel against its own critical limit.
// - Critical limit at code floor of its format disables that channel.
// - Status bits sticky; read clears only after condition has ended.
// - Alert stays asserted while out of limit and until status read.
// - Second-status bit 5 is fourth fan or timer limit exceeded.
`ifndef THERMAL_ALERT_DEFINES_SVH
`define THERMAL_ALERT_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_STATUS1 8'h41
`define ADDR_STATUS2 8'h42
`define ADDR_R1_CFG 8'h5f
`define ADDR_LOC_CFG 8'h60
`define ADDR_R2_CFG 8'h61
`define ADDR_R1_CRIT 8'h6a
`define ADDR_LOC_CRIT 8'h6b
`define ADDR_R2_CRIT 8'h6c
`define ADDR_MASK1 8'h74
`define ADDR_MASK2 8'h75
`define ADDR_PIN_CFG 8'h78
`define ADDR_TIMER 8'h79
`define ADDR_TIMER_LIM 8'h7a
`define ADDR_PIN14_CFG 8'h7d

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define RST_ZERO 8'h00
`define RST_CRIT 8'h64
`define RST_TIMER_LIM 8'h00
`define TIMER_FULL 8'hff
`define TIMER_FIRST 8'h01
`define TIMER_SECOND 8'h02
`define CRIT_OFF_OFS64 8'h00
`define CRIT_OFF_TWOS 8'h80
`define BIT_ALERT_PIN10 0
`define BIT_THERMAL_PIN_EN 1
`define BIT_BOOST 2
`define BIT_CH_THERMAL_PIN_EN 3
`define BIT_SUMMARY 7
`define BIT_F4P 5
`define BIT_OVT 1
`define BIT_CORE_V 1
`define MSK_CORE_V 0

// ----------------------------------------------------------------
// Timer resolution
// ----------------------------------------------------------------
`define TIMER_LSB_NS 22760000
`define CLK_PERIOD_NS 5

`endif

// ---- core/thermal_alert_pkg.sv ----
// Types shared by the thermal alert and assertion timer logic
package thermal_alert_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Temperature with two fraction bits, 0.25 degree steps
  typedef struct packed {
    logic [9:0] r2;
    logic [9:0] loc;
    logic [9:0] r1;
  } temp_set_s;

  typedef enum logic [1:0] {
    PIN14_TACH = 2'b00,
    PIN14_THERMAL_PIN = 2'b10,
    PIN14_ALERT = 2'b01,
    PIN14_GPIO = 2'b11
  } pin14_mode_e;

  typedef enum logic [1:0] {
    TMR_IDLE = 2'b00,
    TMR_FIRST = 2'b01,
    TMR_COUNT = 2'b11,
    TMR_FULL = 2'b10
  } timer_state_e;

endpackage

// ---- core/pin_sync.sv ----
// Two-flop synchroniser for a pin input
`timescale 1ns/100ps
module pin_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Pin level in, synchronised level out
  input wire logic i_pin,
  output logic o_level
);

  logic meta_r;
  logic level_r;

  // Idle pin level is high, so reset to high avoids a false assertion
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      meta_r <= 1'b1;
      level_r <= 1'b1;
    end
    else
    begin
      meta_r <= i_pin;
      level_r <= meta_r;
    end
  end

  assign o_level = level_r;

endmodule

// ---- verif/thermal_alert_chk.sv ----
// Port-level property checker for the thermal alert and timer block
`timescale 1ns/100ps
module thermal_alert_chk
  import thermal_alert_pkg::*;
#(
  parameter int TICK_CYCLES = 4
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Watched ports
  input wire reg_req_s i_reg_req,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic [2:0] i_temp_update,
  input wire logic [2:0] i_fan_running,
  input wire logic i_pin14,
  input wire logic i_pin20,
  input wire logic o_pin20_out,
  input wire logic o_pin20_oe,
  input wire logic [2:0] o_fan_boost,
  input wire logic o_alert_pending
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  read_answer_a: assert property (i_reg_req.rd |=> o_reg_rvalid)
    else $error("read not answered");
  answer_cause_a: assert property (o_reg_rvalid |-> $past(i_reg_req.rd))
    else $error("answer without read");
  rdata_hold_a: assert property (!o_reg_rvalid |-> $stable(o_reg_rdata))
    else $error("read data moved without read");
  pin20_drain_a: assert property (o_pin20_out == 1'b0)
    else $error("thermal pin driven high");
  pin20_cause_a: assert property ($rose(o_pin20_oe) |->
    $past(|i_temp_update) || $past(i_reg_req.wr) || $past(i_reg_req.wr, 2))
    else $error("thermal drive without new reading");
  boost_fans_a: assert property (o_fan_boost == 3'h0 ||
    o_fan_boost == $past(i_fan_running))
    else $error("boost on a fan that is not running");
  boost_cause_a: assert property (o_fan_boost != 3'h0 |->
    $past(i_pin20 & i_pin14, 3) == 1'b0 || $past(i_pin20 & i_pin14, 4) == 1'b0)
    else $error("boost without thermal input low");
  alert_hold_a: assert property ($fell(o_alert_pending) |->
    $past(i_reg_req.rd || i_reg_req.wr, 2))
    else $error("alert released without access");

  read_c: cover property (i_reg_req.rd ##1 o_reg_rvalid);
  boost_c: cover property (o_fan_boost != 3'h0);
  alert_c: cover property ($fell(o_alert_pending));
  drive_c: cover property ($rose(o_pin20_oe));
endmodule

bind thermal_alert_timer_logic thermal_alert_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .i_clk, .i_sys_rst, .i_reg_req, .o_reg_rdata, .o_reg_rvalid, .i_temp_update,
  .i_fan_running, .i_pin14, .i_pin20, .o_pin20_out, .o_pin20_oe, .o_fan_boost,
  .o_alert_pending
);

// ---- verif/proc_hot_model.sv ----
// Processor hot line model on a pulled-up open-drain wire
`timescale 1ns/100ps
module proc_hot_model (
  // Clock
  input wire logic i_clk,
  // Device side of the wire
  input wire logic i_dev_oe,
  input wire logic i_dev_out,
  // Resolved wire level
  output logic o_line
);
  logic hot_r = 1'b0;

  // Pull-up wins only when nobody pulls low
  assign o_line = i_dev_oe ? (i_dev_out & ~hot_r) : ~hot_r;

  task automatic hold_low(input int n);
    hot_r <= 1'b1;
    repeat (n) @(posedge i_clk);
    hot_r <= 1'b0;
  endtask
endmodule

// ---- verif/tb_thermal_alert_timer_logic.sv ----
// Self-checking bench for the thermal alert and timer block
`timescale 1ns/100ps
`include "thermal_alert_defines.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_thermal_alert_timer_logic;
  import thermal_alert_pkg::*;
  localparam int T = 4;
  int errors = 0;
  int n_tests = 0;
  int seed = 32'hab88;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  reg_req_s i_reg_req = '0;
  logic [7:0] i_status1_cond = 8'h00;
  logic [7:0] i_status2_cond = 8'h00;
  temp_set_s i_temps = '0;
  logic [2:0] i_temp_update = 3'h0;
  logic i_offset64_mode = 1'b0;
  logic [2:0] i_fan_running = 3'h0;
  logic i_second_fan_drive = 1'b1, i_gpio_out = 1'b0, i_gpio_oe = 1'b0;
  wire i_pin14, i_pin20;
  logic [7:0] o_reg_rdata;
  logic o_pin10_out, o_pin10_oe, o_pin14_out, o_pin14_oe, o_pin20_out, o_pin20_oe;
  logic o_alert_pending, a, o_reg_rvalid, o_gpio_in;
  logic [2:0] o_fan_boost;
  logic [7:0] m1, m2, s1, s2, lim, c;
  int n1, n2;
  logic [7:0] rw [11] = '{`ADDR_R1_CFG, `ADDR_LOC_CFG, `ADDR_R2_CFG, `ADDR_R1_CRIT,
    `ADDR_LOC_CRIT, `ADDR_R2_CRIT, `ADDR_MASK1, `ADDR_MASK2, `ADDR_PIN_CFG,
    `ADDR_TIMER_LIM, `ADDR_PIN14_CFG};
  logic [7:0] ro [4] = '{`ADDR_STATUS1, `ADDR_STATUS2, `ADDR_TIMER, 8'h50};

  thermal_alert_timer_logic #(.TICK_CYCLES(T)) dut_u (
    .i_clk, .i_sys_rst, .i_reg_req, .o_reg_rdata, .o_reg_rvalid,
    .i_status1_cond, .i_status2_cond, .i_temps, .i_temp_update, .i_offset64_mode,
    .i_fan_running, .i_second_fan_drive, .i_gpio_out, .i_gpio_oe,
    .o_pin10_out, .o_pin10_oe, .i_pin14, .o_pin14_out, .o_pin14_oe,
    .i_pin20, .o_pin20_out, .o_pin20_oe, .o_fan_boost, .o_alert_pending, .o_gpio_in
  );
  proc_hot_model p20_u (.i_clk, .i_dev_oe(o_pin20_oe), .i_dev_out(o_pin20_out),
    .o_line(i_pin20));
  proc_hot_model p14_u (.i_clk, .i_dev_oe(o_pin14_oe), .i_dev_out(o_pin14_out),
    .o_line(i_pin14));

  initial
  begin
    forever #2.5 i_clk = ~i_clk;
  end

  // ------------------------------------------------------------
  // Bus cycles and expectations
  // ------------------------------------------------------------
  task automatic acc(input logic w, input logic [7:0] ad, d, output logic [7:0] q);
    i_reg_req <= '{ad, d, w, !w};
    @(posedge i_clk);
    i_reg_req <= '0;
    #1 q = o_reg_rdata;
    `CHK("rvalid", !w, o_reg_rvalid)
    @(posedge i_clk);
  endtask

  task automatic wr(input logic [7:0] ad, d);
    logic [7:0] q;
    acc(1'b1, ad, d, q);
  endtask

  task automatic rchk(input logic [7:0] ad, e);
    logic [7:0] q;
    acc(1'b0, ad, 8'h00, q);
    `CHK("read", e, q)
  endtask

  // One temperature update on a channel, then look at the thermal drive
  task automatic tdrive(input int ch, input logic [9:0] t, input logic e);
    i_temps <= {t, t, t};
    i_temp_update <= 3'(1 << ch);
    @(posedge i_clk);
    i_temp_update <= 3'h0;
    repeat (4) @(posedge i_clk);
    #1;
    `CHK("pin20_oe", e, o_pin20_oe)
    @(posedge i_clk);
  endtask

  function automatic logic alert_exp(input logic [7:0] x1, x2, k1, k2);
    return |{|(x2 & ~k2) & ~k1[7], x1[6:2] & ~k1[6:2], x1[1] & ~k1[0], x1[0]};
  endfunction

  // Timer value after n asserted cycles
  function automatic logic [7:0] tval(input int n);
    if (n == 0)
      return 8'h00;
    if (n <= 2 * T)
      return 8'h01;
    return ((n - 1) / T > 255) ? 8'hff : 8'((n - 1) / T);
  endfunction

  task automatic end_sim();
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    foreach (rw[i])
      rchk(rw[i], (i inside {[3:5]}) ? `RST_CRIT : `RST_ZERO);
    foreach (ro[i])
    begin
      rchk(ro[i], 8'h00);
      wr(ro[i], 8'hff);
      rchk(ro[i], 8'h00);
    end
    foreach (rw[i])
    begin
      c = 8'($random(seed));
      wr(rw[i], c);
      rchk(rw[i], c);
      wr(rw[i], 8'h00);
    end
    for (int k = 0; k < 12; k++)
    begin
      m1 = 8'($random(seed));
      m2 = 8'($random(seed));
      s1 = 8'($random(seed));
      s2 = 8'($random(seed));
      a = alert_exp(s1, s2, m1, m2);
      wr(`ADDR_MASK1, m1);
      wr(`ADDR_MASK2, m2);
      wr(`ADDR_PIN_CFG, 8'(k % 2));
      wr(`ADDR_PIN14_CFG, 8'h01);
      i_status1_cond <= s1;
      i_status2_cond <= s2;
      repeat (4) @(posedge i_clk);
      #1;
      `CHK("alert", a, o_alert_pending)
      `CHK("pin10", (k % 2) ? {a, 1'b0} : 2'b11, {o_pin10_oe, o_pin10_out})
      `CHK("pin14_oe", a, o_pin14_oe)
      @(posedge i_clk);
      rchk(`ADDR_STATUS1, {|s2, s1[6:0]});
      i_status1_cond <= 8'h00;
      i_status2_cond <= 8'h00;
      rchk(`ADDR_STATUS2, s2);
      rchk(`ADDR_STATUS1, {1'b0, s1[6:0]});
      rchk(`ADDR_STATUS1, 8'h00);
      #1;
      `CHK("alert_clr", 1'b0, o_alert_pending)
      @(posedge i_clk);
    end
    wr(`ADDR_PIN14_CFG, 8'h00);
    wr(`ADDR_PIN_CFG, 8'h02);
    wr(`ADDR_MASK1, 8'h00);
    wr(`ADDR_MASK2, 8'h00);
    repeat (4)
    begin
      lim = 8'(1 + {$random(seed)} % 4);
      n1 = T * ({$random(seed)} % 5) + 1;
      n2 = T * ({$random(seed)} % 5) + 1;
      wr(`ADDR_TIMER_LIM, lim);
      p20_u.hold_low(n1);
      repeat (3) @(posedge i_clk);
      p20_u.hold_low(n2);
      repeat (6) @(posedge i_clk);
      #1;
      `CHK("alert_tmr", tval(n1 + n2) > lim, o_alert_pending)
      @(posedge i_clk);
      rchk(`ADDR_TIMER, tval(n1 + n2));
      rchk(`ADDR_TIMER, 8'h00);
      rchk(`ADDR_STATUS2, (tval(n1 + n2) > lim) ? 8'h20 : 8'h00);
    end
    wr(`ADDR_MASK2, 8'h20);
    p20_u.hold_low(T * 300);
    repeat (6) @(posedge i_clk);
    #1;
    `CHK("alert_msk", 1'b0, o_alert_pending)
    @(posedge i_clk);
    rchk(`ADDR_TIMER, 8'hff);
    rchk(`ADDR_STATUS2, 8'h20);
    wr(`ADDR_TIMER_LIM, 8'h00);
    fork
      p20_u.hold_low(40);
      begin
        repeat (20) @(posedge i_clk);
        acc(1'b0, `ADDR_TIMER, 8'h00, c);
        repeat (2) @(posedge i_clk);
        rchk(`ADDR_TIMER, 8'h01);
        rchk(`ADDR_STATUS2, 8'h20);
      end
    join
    repeat (4) @(posedge i_clk);
    acc(1'b0, `ADDR_TIMER, 8'h00, c);
    wr(`ADDR_PIN14_CFG, 8'h02);
    p14_u.hold_low(6);
    repeat (4) @(posedge i_clk);
    rchk(`ADDR_TIMER, 8'h01);
    wr(`ADDR_PIN_CFG, 8'h00);
    p20_u.hold_low(6);
    p14_u.hold_low(6);
    repeat (4) @(posedge i_clk);
    rchk(`ADDR_TIMER, 8'h00);
    wr(`ADDR_PIN_CFG, 8'h02);
    for (int ch = 0; ch < 3; ch++)
    begin
      for (int k = 0; k < 3; k++)
      begin
        c = {2'b01, 6'($random(seed))};
        a = 1'($random(seed));
        i_offset64_mode <= a;
        wr(`ADDR_R1_CFG + 8'(ch), (k == 1) ? 8'h00 : 8'h08);
        wr(`ADDR_R1_CRIT + 8'(ch), (k < 2) ? c : (a ? 8'h00 : 8'h80));
        tdrive(ch, {c, 2'b01}, k == 0);
        tdrive(ch, {c, 2'b10}, k == 0);
        tdrive(ch, {c, 2'b00}, 1'b0);
      end
    end
    for (int b = 0; b < 2; b++)
    begin
      i_fan_running <= 3'($random(seed));
      wr(`ADDR_PIN_CFG, b ? 8'h06 : 8'h02);
      fork
        p20_u.hold_low(12);
        begin
          repeat (8) @(posedge i_clk);
          #1;
          `CHK("boost", b ? i_fan_running : 3'h0, o_fan_boost)
        end
      join
    end
    wr(`ADDR_PIN14_CFG, 8'h03);
    repeat (4)
    begin
      i_gpio_out <= 1'($random(seed));
      i_gpio_oe <= 1'($random(seed));
      i_second_fan_drive <= 1'($random(seed));
      repeat (4) @(posedge i_clk);
      #1;
      `CHK("gpio", {i_gpio_oe, i_gpio_out, i_gpio_oe ? i_gpio_out : 1'b1}, {o_pin14_oe, o_pin14_out, o_gpio_in})
      `CHK("pin10_fan", {1'b1, i_second_fan_drive}, {o_pin10_oe, o_pin10_out})
      @(posedge i_clk);
    end
    end_sim();
  end

  // Hang guard, well past the expected run length
  initial
  begin
    #200000;
    errors++;
    end_sim();
  end
endmodule
